/* core/indirect_pkg.sv */
package indirect_pkg;

    // ============================================================
    // Address space
    // ============================================================
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned PAIR_COUNT = 3;

    // Pair 0 sits at the top of the special-function space, each further
    // pair one block of eight bytes lower
    localparam logic [11:0] PAIR0_TOP   = 12'hFEF;
    localparam logic [11:0] PAIR_SPAN   = 12'h018;
    localparam logic [11:0] INDIRECT_ACCESS_PORT_ONE = 12'hFE7;

    // ============================================================
    // Slot offsets below each pair's top address
    // ============================================================
    localparam logic [2:0] SLOT_PLAIN       = 3'h0;
    localparam logic [2:0] SLOT_INC_AFTER   = 3'h1;
    localparam logic [2:0] SLOT_DEC_AFTER   = 3'h2;
    localparam logic [2:0] SLOT_INC_BEFORE  = 3'h3;
    localparam logic [2:0] SLOT_PLUS_ACC    = 3'h4;
    localparam logic [2:0] SLOT_PTR_HIGH    = 3'h5;
    localparam logic [2:0] SLOT_PTR_LOW     = 3'h6;

    // ============================================================
    // Direct operand decode
    // ============================================================
    localparam logic [7:0] ACCESS_LOW_LIMIT = 8'h5F;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;
    localparam logic [3:0] ACCESS_LOW_PAGE  = 4'h0;

    // ============================================================
    // Reset values and answer sources
    // ============================================================
    localparam logic [7:0] POINTER_RESET = 8'h00;
    localparam logic [7:0] NESTED_READ   = 8'h00;

    typedef enum logic [1:0] {
        SRC_MEMORY,
        SRC_OWN,
        SRC_NONE
    } answer_src_t;

endpackage

/* core/pointer_pair.sv */
`timescale 1ns/100ps
module pointer_pair (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        write_low_i,
    input  wire logic        write_high_i,
    input  wire logic [7:0]  write_data_i,
    input  wire logic        step_i,
    input  wire logic        step_down_i,
    output logic      [15:0] value_o
);

    logic [7:0] pointer_low_byte;
    logic [7:0] pointer_high_byte;
    logic [7:0] next_pointer_low_byte;
    logic [7:0] next_pointer_high_byte;
    logic [15:0] stepped;

    // ============================================================
    // Next value
    // ============================================================
    always_comb begin
        // Whole 16-bit step so a low-byte wrap carries into the high byte
        if (step_down_i) begin
            stepped = {pointer_high_byte, pointer_low_byte} - 16'h0001; // [R01]
        end else begin
            stepped = {pointer_high_byte, pointer_low_byte} + 16'h0001; // [R01]
        end
        next_pointer_low_byte  = pointer_low_byte;
        next_pointer_high_byte = pointer_high_byte;
        if (step_i) begin
            next_pointer_low_byte  = stepped[7:0];
            next_pointer_high_byte = stepped[15:8];
        end
        // Stored bytes as written, with no step applied
        if (write_low_i) begin
            next_pointer_low_byte = write_data_i; // [R06] [R07]
        end
        if (write_high_i) begin
            next_pointer_high_byte = write_data_i; // [R06] [R07]
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            pointer_low_byte  <= indirect_pkg::POINTER_RESET;
            pointer_high_byte <= indirect_pkg::POINTER_RESET;
        end else begin
            pointer_low_byte  <= next_pointer_low_byte;
            pointer_high_byte <= next_pointer_high_byte;
        end
    end

    assign value_o = {pointer_high_byte, pointer_low_byte};

endmodule // pointer_pair

/* core/indirect_addressing_unit.sv */
`timescale 1ns/100ps
// Behaviour
// R01: Auto-modify steps the full 16-bit pointer pair, carrying between bytes.
// R02: Pointer steps never touch arithmetic status flags.
// R03: Plus-accumulator slot addresses pointer plus accumulator value.
// R04: Indirect read landing on a virtual register returns zero.
// R05: Indirect write landing on a virtual register does nothing.
// R06: Writes to a pointer through its own slots store plainly, no step.
// R07: Pointer bytes are real registers reachable by direct access.
// R08: Indirect access reaches every other special register like direct access.
// R09: Extended set enable adds indexed mode for access-bank operands.
// R10: Extended mode keeps memory size, linear addressing and register map.
// R11: Pairs zero and one act the same in extended mode.
// R12: Extended mode keeps direct and indirect core addressing.
// R13: Extended, access bit 0, file up to 5Fh: pair two plus offset.
// R14: Access bit 1 or file 60h upward stays normal direct addressing.
// R15: Every pair has its own five virtual slots.
// R16: Indirect targets are cut to the data address width.
module indirect_addressing_unit (
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic        EXTENDED_SET_ENABLE_I,
    input  wire logic        REQ_VALID_I,
    input  wire logic        REQ_WRITE_I,
    input  wire logic        REQ_FULL_I,
    input  wire logic [11:0] REQ_FULL_ADDR_I,
    input  wire logic        REQ_ACCESS_BIT_I,
    input  wire logic [7:0]  REQ_FILE_I,
    input  wire logic [3:0]  REQ_BANK_I,
    input  wire logic [7:0]  REQ_WDATA_I,
    input  wire logic [7:0]  ACCUMULATOR_I,
    input  wire logic [7:0]  MEM_RDATA_I,
    output logic             MEM_VALID_O,
    output logic             MEM_WRITE_O,
    output logic      [11:0] MEM_ADDR_O,
    output logic      [7:0]  MEM_WDATA_O,
    output logic             RESP_VALID_O,
    output logic      [7:0]  RESP_DATA_O
);

    localparam int unsigned N = indirect_pkg::PAIR_COUNT;

    logic [15:0] pair_value [N];
    logic [N-1:0] wr_low;
    logic [N-1:0] wr_high;
    logic [N-1:0] step;
    logic [N-1:0] step_down;

    // ============================================================
    // Pointer pairs
    // ============================================================
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_pair
            pointer_pair u_pair ( // [R15]
                .clk_i        (MCLK_I),
                .reset_i      (RESET_I),
                .write_low_i  (wr_low[gi]),
                .write_high_i (wr_high[gi]),
                .write_data_i (REQ_WDATA_I),
                .step_i       (step[gi]),
                .step_down_i  (step_down[gi]),
                .value_o      (pair_value[gi])
            );
        end
    endgenerate

    // Maps an address to a hit flag and pair number; hit is low outside the pair area
    function automatic logic [3:0] decode(input logic [11:0] a);
        logic [11:0] d;
        d = indirect_pkg::PAIR0_TOP - a;
        if (a <= indirect_pkg::PAIR0_TOP && d < indirect_pkg::PAIR_SPAN
            && d[2:0] != 3'h7) begin
            decode = {1'b1, d[4:3], 1'b0};
        end else begin
            decode = 4'h0;
        end
    endfunction

    // ============================================================
    // Request resolution
    // ============================================================
    logic [11:0] eff_addr;
    logic [11:0] target;
    logic [11:0] direct_pair_sum;
    logic [15:0] ptr;
    logic [3:0]  d_dec;
    logic [3:0]  t_dec;
    logic [1:0]  d_pair;
    logic [1:0]  t_pair;
    logic [2:0]  d_slot;
    logic [2:0]  t_slot;
    logic        own_access;
    logic [1:0]  own_pair;
    logic        own_high;
    logic        nested;
    logic        to_memory;
    logic [11:0] mem_target;

    always_comb begin
        direct_pair_sum = pair_value[2][11:0] + {4'h0, REQ_FILE_I};
        if (REQ_FULL_I) begin
            eff_addr = REQ_FULL_ADDR_I;
        end else if (REQ_ACCESS_BIT_I) begin
            eff_addr = {REQ_BANK_I, REQ_FILE_I}; // [R14]
        end else if (REQ_FILE_I <= indirect_pkg::ACCESS_LOW_LIMIT) begin
            if (EXTENDED_SET_ENABLE_I) begin
                // Indexed literal offset via pair two only; pairs zero and one untouched
                eff_addr = direct_pair_sum; // [R09] [R13] [R11]
            end else begin
                eff_addr = {indirect_pkg::ACCESS_LOW_PAGE, REQ_FILE_I};
            end
        end else begin
            // Same map and linear layout with or without the extended set
            eff_addr = {indirect_pkg::ACCESS_HIGH_PAGE, REQ_FILE_I}; // [R10] [R12] [R14]
        end

        d_dec  = decode(eff_addr);
        d_pair = d_dec[2:1];
        d_slot = 3'(indirect_pkg::PAIR0_TOP - eff_addr);
        ptr    = pair_value[d_pair];
        case (d_slot)
            indirect_pkg::SLOT_INC_BEFORE: target = ptr[11:0] + 12'h001; // [R16]
            indirect_pkg::SLOT_PLUS_ACC:
                target = ptr[11:0] + {{4{ACCUMULATOR_I[7]}}, ACCUMULATOR_I}; // [R03] [R16]
            default: target = ptr[11:0]; // [R16]
        endcase
        t_dec  = decode(target);
        t_pair = t_dec[2:1];
        t_slot = 3'(indirect_pkg::PAIR0_TOP - target);

        wr_low     = '0;
        wr_high    = '0;
        step       = '0;
        step_down  = '0;
        own_access = 1'b0;
        own_pair   = 2'h0;
        own_high   = 1'b0;
        nested     = 1'b0;
        to_memory  = 1'b0;
        mem_target = eff_addr;

        if (REQ_VALID_I) begin
            if (d_dec[3] && d_slot <= indirect_pkg::SLOT_PLUS_ACC) begin
                if (t_dec[3] && t_slot <= indirect_pkg::SLOT_PLUS_ACC) begin
                    // No nested indirection: read gives zero, write is dropped
                    nested = 1'b1; // [R04] [R05]
                end else begin
                    if (t_dec[3]) begin
                        own_access = 1'b1;
                        own_pair   = t_pair;
                        own_high   = (t_slot == indirect_pkg::SLOT_PTR_HIGH);
                    end else begin
                        to_memory  = 1'b1; // [R08]
                        mem_target = target;
                    end
                    // A write onto this pair's own bytes stores plainly, no step
                    if (!(REQ_WRITE_I && t_dec[3] && t_pair == d_pair)) begin // [R06]
                        // Only the pointer moves; no status flag is produced here
                        step[d_pair] = (d_slot == indirect_pkg::SLOT_INC_AFTER)
                                    || (d_slot == indirect_pkg::SLOT_DEC_AFTER)
                                    || (d_slot == indirect_pkg::SLOT_INC_BEFORE); // [R01] [R02]
                        step_down[d_pair] = (d_slot == indirect_pkg::SLOT_DEC_AFTER);
                    end
                end
            end else if (d_dec[3]) begin
                own_access = 1'b1; // [R07]
                own_pair   = d_pair;
                own_high   = (d_slot == indirect_pkg::SLOT_PTR_HIGH);
            end else begin
                to_memory = 1'b1;
            end
            if (own_access && REQ_WRITE_I) begin
                wr_low[own_pair]  = !own_high; // [R06] [R07]
                wr_high[own_pair] = own_high;
            end
        end
    end

    // ============================================================
    // Two-stage answer pipeline
    // ============================================================
    logic        mem_valid;
    logic        mem_write;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        pend_read;
    indirect_pkg::answer_src_t pend_src;
    logic [7:0]  own_data;
    logic        resp_valid;
    logic [7:0]  resp_data;
    logic        next_mem_valid;
    logic        next_mem_write;
    logic [11:0] next_mem_addr;
    logic [7:0]  next_mem_wdata;
    logic        next_pend_read;
    indirect_pkg::answer_src_t next_pend_src;
    logic [7:0]  next_own_data;
    logic        next_resp_valid;
    logic [7:0]  next_resp_data;
    logic [15:0] own_value;

    always_comb begin
        own_value       = pair_value[own_pair];
        next_mem_valid  = to_memory;
        next_mem_write  = to_memory && REQ_WRITE_I;
        next_mem_addr   = to_memory ? mem_target : mem_addr;
        next_mem_wdata  = to_memory ? REQ_WDATA_I : mem_wdata;
        next_pend_read  = REQ_VALID_I && !REQ_WRITE_I;
        next_pend_src   = nested ? indirect_pkg::SRC_NONE
                        : (own_access ? indirect_pkg::SRC_OWN : indirect_pkg::SRC_MEMORY);
        next_own_data   = own_high ? own_value[15:8] : own_value[7:0];
        next_resp_valid = pend_read;
        case (pend_src)
            indirect_pkg::SRC_MEMORY: next_resp_data = MEM_RDATA_I;
            indirect_pkg::SRC_OWN:    next_resp_data = own_data;
            indirect_pkg::SRC_NONE:   next_resp_data = indirect_pkg::NESTED_READ; // [R04]
            default:                  next_resp_data = indirect_pkg::NESTED_READ;
        endcase
        if (!pend_read) begin
            next_resp_data = resp_data;
        end
    end

    always_ff @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            mem_valid  <= 1'b0;
            mem_write  <= 1'b0;
            mem_addr   <= 12'h000;
            mem_wdata  <= 8'h00;
            pend_read  <= 1'b0;
            pend_src   <= indirect_pkg::SRC_MEMORY;
            own_data   <= 8'h00;
            resp_valid <= 1'b0;
            resp_data  <= 8'h00;
        end else begin
            mem_valid  <= next_mem_valid;
            mem_write  <= next_mem_write;
            mem_addr   <= next_mem_addr;
            mem_wdata  <= next_mem_wdata;
            pend_read  <= next_pend_read;
            pend_src   <= next_pend_src;
            own_data   <= next_own_data;
            resp_valid <= next_resp_valid;
            resp_data  <= next_resp_data;
        end
    end

    assign MEM_VALID_O  = mem_valid;
    assign MEM_WRITE_O  = mem_write;
    assign MEM_ADDR_O   = mem_addr;
    assign MEM_WDATA_O  = mem_wdata;
    assign RESP_VALID_O = resp_valid;
    assign RESP_DATA_O  = resp_data;

endmodule // indirect_addressing_unit

/* sim/data_memory_model.sv */
`timescale 1ns/100ps
module data_memory_model (
    input  wire logic        clk_i,
    input  wire logic        valid_i,
    input  wire logic [11:0] addr_i,
    output logic      [7:0]  rdata_o
);
    logic [7:0] last;
    logic [7:0] next_last;

    // ============================================================
    // Combinational read; between strokes the bus shows the inverse
    // ============================================================
    always_comb begin
        next_last = last;
        rdata_o = ~last;
        if (valid_i) begin
            rdata_o = addr_i[7:0] ^ {addr_i[11:8], addr_i[11:8]};
            next_last = rdata_o;
        end
    end

    always_ff @(posedge clk_i) begin
        last <= next_last;
    end
endmodule // data_memory_model

/* sim/indirect_addressing_unit_sva.sv */
`timescale 1ns/100ps
module indirect_addressing_unit_chk (
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    input  wire logic        EXTENDED_SET_ENABLE_I,
    input  wire logic        REQ_VALID_I,
    input  wire logic        REQ_WRITE_I,
    input  wire logic        REQ_FULL_I,
    input  wire logic [11:0] REQ_FULL_ADDR_I,
    input  wire logic        REQ_ACCESS_BIT_I,
    input  wire logic [7:0]  REQ_FILE_I,
    input  wire logic [3:0]  REQ_BANK_I,
    input  wire logic [7:0]  REQ_WDATA_I,
    input  wire logic [7:0]  MEM_RDATA_I,
    input  wire logic        MEM_VALID_O,
    input  wire logic        MEM_WRITE_O,
    input  wire logic [11:0] MEM_ADDR_O,
    input  wire logic [7:0]  MEM_WDATA_O,
    input  wire logic        RESP_VALID_O,
    input  wire logic [7:0]  RESP_DATA_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);

    // ============================================================
    // Sequences
    // ============================================================
    sequence s_plain;
        REQ_VALID_I && REQ_FULL_I && (REQ_FULL_ADDR_I < 12'hFD9);
    endsequence
    sequence s_oper;
        REQ_VALID_I && !REQ_FULL_I;
    endsequence
    sequence s_strobe;
        MEM_VALID_O ##1 RESP_VALID_O;
    endsequence

    // ============================================================
    // Properties
    // ============================================================
    property p_mem_addr;
        s_plain |=> MEM_VALID_O && (MEM_ADDR_O == $past(REQ_FULL_ADDR_I));
    endproperty
    a_mem_addr: assert property (p_mem_addr) else $error("memory address wrong");
    property p_mem_write;
        s_plain |=> (MEM_WRITE_O == $past(REQ_WRITE_I))
            && (!MEM_WRITE_O || (MEM_WDATA_O == $past(REQ_WDATA_I)));
    endproperty
    a_mem_write: assert property (p_mem_write) else $error("memory write wrong");
    property p_read_path;
        s_plain ##0 !REQ_WRITE_I |=> s_strobe ##0 (RESP_DATA_O == $past(MEM_RDATA_I));
    endproperty
    a_read_path: assert property (p_read_path) else $error("read answer wrong");
    property p_write_silent;
        REQ_VALID_I && REQ_WRITE_I |-> ##2 !RESP_VALID_O;
    endproperty
    a_write_silent: assert property (p_write_silent) else $error("write answered");
    property p_idle;
        !REQ_VALID_I |-> ##1 !MEM_VALID_O ##1 !RESP_VALID_O;
    endproperty
    a_idle: assert property (p_idle) else $error("activity without request");
    property p_ptr_internal;
        REQ_VALID_I && REQ_FULL_I && (REQ_FULL_ADDR_I inside {12'hFE9, 12'hFEA,
            12'hFE1, 12'hFE2, 12'hFD9, 12'hFDA}) |=> !MEM_VALID_O;
    endproperty
    a_ptr_internal: assert property (p_ptr_internal) else $error("pointer on bus");
    property p_access_low;
        s_oper ##0 !REQ_ACCESS_BIT_I && (REQ_FILE_I <= 8'h5F) && !EXTENDED_SET_ENABLE_I
            |=> MEM_VALID_O && (MEM_ADDR_O == {4'h0, $past(REQ_FILE_I)});
    endproperty
    a_access_low: assert property (p_access_low) else $error("access low wrong");
    property p_access_high;
        s_oper ##0 !REQ_ACCESS_BIT_I && (REQ_FILE_I >= 8'h60) && (REQ_FILE_I < 8'hD9)
            |=> MEM_VALID_O && (MEM_ADDR_O == {4'hF, $past(REQ_FILE_I)});
    endproperty
    a_access_high: assert property (p_access_high) else $error("access high wrong");
    property p_banked;
        s_oper ##0 REQ_ACCESS_BIT_I && (REQ_BANK_I != 4'hF)
            |=> MEM_VALID_O && (MEM_ADDR_O == $past({REQ_BANK_I, REQ_FILE_I}));
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");
endmodule // indirect_addressing_unit_chk

bind indirect_addressing_unit indirect_addressing_unit_chk u_chk (.*);

/* sim/tb_indirect_addressing_unit.sv */
`timescale 1ns/100ps
module tb_indirect_addressing_unit;
    logic        clk, rst, ext, ext_next, vld, wr, full, a_bit, mv, mw, resp_v;
    logic [11:0] fa, maddr;
    logic [7:0]  file, wd, accv, rdata, mwd, rd, av;
    logic [3:0]  bank;
    logic [15:0] v;
    int          fails, n_tests, cyc;

    indirect_addressing_unit dut (.MCLK_I(clk), .RESET_I(rst), .EXTENDED_SET_ENABLE_I(ext),
        .REQ_VALID_I(vld), .REQ_WRITE_I(wr), .REQ_FULL_I(full), .REQ_FULL_ADDR_I(fa),
        .REQ_ACCESS_BIT_I(a_bit), .REQ_FILE_I(file), .REQ_BANK_I(bank), .REQ_WDATA_I(wd),
        .ACCUMULATOR_I(accv), .MEM_RDATA_I(rdata), .MEM_VALID_O(mv), .MEM_WRITE_O(mw),
        .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .RESP_VALID_O(resp_v), .RESP_DATA_O(rd));
    data_memory_model mem (.clk_i(clk), .valid_i(mv), .addr_i(maddr), .rdata_o(rdata));

    // ============================================================
    // Helpers
    // ============================================================
    function automatic logic [7:0] memv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]};
    endfunction
    function automatic logic [11:0] top(input int n);
        return 12'hFEF - 12'(8 * n);
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One request, then the strobe one cycle later and the answer one more
    task automatic req(input logic w, input logic f, input logic [11:0] ad, input logic a,
        input logic [7:0] fl, input logic [3:0] bk, input logic [7:0] wdv, input logic [7:0] acv,
        input logic ev, input logic [11:0] ea, input logic er, input logic [7:0] ed);
        @(posedge clk);
        vld <= 1'b1; wr <= w; full <= f; fa <= ad; a_bit <= a; file <= fl;
        bank <= bk; wd <= wdv; accv <= acv; ext <= ext_next;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        check(mv, ev);
        if (ev) check(maddr, ea);
        if (ev) check(mw, w);
        if (ev && w) check(mwd, wdv);
        @(posedge clk);
        #1;
        check(resp_v, er);
        if (er) check(rd, ed);
    endtask
    task automatic fr(input logic w, input logic [11:0] ad, input logic [7:0] d,
        input logic ev, input logic er, input logic [7:0] ed);
        req(w, 1'b1, ad, 1'b0, 8'h00, 4'h0, d, 8'h00, ev, ad, er, ed);
    endtask
    task automatic mrd(input logic [11:0] ad, input logic [11:0] ea);
        req(1'b0, 1'b1, ad, 1'b0, 8'h00, 4'h0, 8'h00, 8'h00, 1'b1, ea, 1'b1, memv(ea));
    endtask
    task automatic setp(input int n, input logic [15:0] pv);
        fr(1'b1, top(n) - 12'h006, pv[7:0], 1'b0, 1'b0, 8'h00);
        fr(1'b1, top(n) - 12'h005, pv[15:8], 1'b0, 1'b0, 8'h00);
    endtask
    task automatic opr(input logic a, input logic [7:0] fl, input logic [3:0] bk,
        input logic [11:0] ea);
        req(1'b0, 1'b0, 12'h000, a, fl, bk, 8'h00, 8'h00, 1'b1, ea, 1'b1, memv(ea));
    endtask
    task automatic summarize();
        $display("tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ============================================================
    // Clock, reset and hang guard
    // ============================================================
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Whole run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            summarize();
        end
    end

    // ============================================================
    // Tests
    // ============================================================
    initial begin
        {ext, ext_next, vld, wr, full, a_bit, file, wd, accv, bank, fa} = '0;
        fails = 0; n_tests = 0; rst = 1'b1;
        void'($urandom(33323));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        setp(0, 16'hA1FF);
        fr(1'b0, 12'hFEA, 8'h00, 1'b0, 1'b1, 8'hA1);
        mrd(12'hFEE, 12'h1FF);
        fr(1'b0, 12'hFEA, 8'h00, 1'b0, 1'b1, 8'hA2);
        mrd(12'hFED, 12'h200);
        mrd(12'hFEF, 12'h1FF);
        mrd(12'hFEC, 12'h200);
        av = 8'($urandom);
        req(1'b0, 1'b1, 12'hFEB, 1'b0, 8'h00, 4'h0, 8'h00, av, 1'b1,
            12'h200 + {{4{av[7]}}, av}, 1'b1, memv(12'h200 + {{4{av[7]}}, av}));
        $display("test steps done");
        for (int e = 0; e < 2; e++) begin
            ext_next = e[0];
            for (int n = 0; n < 3; n++) begin
                v = 16'($urandom_range(0, 12'hD00));
                setp(n, v);
                mrd(top(n), v[11:0]);
            end
        end
        ext_next = 1'b0;
        $display("test pairs done");
        setp(0, 16'h0FE7);
        fr(1'b0, 12'hFEE, 8'h00, 1'b0, 1'b1, 8'h00);
        fr(1'b1, 12'hFEF, 8'hAA, 1'b0, 1'b0, 8'h00);
        fr(1'b0, 12'hFE9, 8'h00, 1'b0, 1'b1, 8'hE7);
        setp(2, 16'h0FD9);
        fr(1'b1, 12'hFDD, 8'h55, 1'b0, 1'b0, 8'h00);
        fr(1'b0, 12'hFD9, 8'h00, 1'b0, 1'b1, 8'h55);
        fr(1'b0, 12'hFDA, 8'h00, 1'b0, 1'b1, 8'h0F);
        $display("test nested done");
        setp(2, 16'h0123);
        ext_next = 1'b1;
        opr(1'b0, 8'h10, 4'h0, 12'h133);
        opr(1'b0, 8'h5F, 4'h0, 12'h182);
        opr(1'b0, 8'h60, 4'h0, 12'hF60);
        opr(1'b1, 8'h05, 4'h3, 12'h305);
        ext_next = 1'b0;
        opr(1'b0, 8'h10, 4'h0, 12'h010);
        $display("test extended done");
        repeat (20) begin
            ext_next = 1'($urandom);
            // Kept at or below FD8h, off the pair area; every random access goes to memory
            v = 16'($urandom_range(0, 12'hFD8));
            if ($urandom_range(0, 1) == 1) fr(1'b1, v[11:0], 8'($urandom), 1'b1, 1'b0, 8'h00);
            else mrd(v[11:0], v[11:0]);
        end
        $display("test random done");
        summarize();
    end
endmodule // tb_indirect_addressing_unit
